// ### verilog/nvm_decoder_pkg.sv
// Constants shared by the flash and EEPROM instruction decoder
package nvm_decoder_pkg;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_READ_ID = 8'h90;
  localparam logic [7:0] CODE_PROTECT_OFF = 8'h20;
  localparam logic [7:0] CODE_RETURN = 8'hF0;
  localparam logic [2:0] SEL_IDENT = 3'h1;
  localparam logic [2:0] SEL_PROTECT = 3'h2;
  localparam logic [5:0] OTP_LAST = 6'h3F;
  localparam logic [6:0] BURST_MAX = 7'h40;
  // Clock rate and documented times
  localparam int CLK_HZ = 25000000;
  localparam int TIMEOUT_US = 80;
  localparam int LOCKOUT_MS = 5;
  localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int LOCKOUT_CYC = LOCKOUT_MS * (CLK_HZ / 1000);
  localparam int OP_CYC = 16;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
endpackage : nvm_decoder_pkg

// ### verilog/nvm_instruction_decoder.sv
// Instruction sequence decoder for the main flash and secondary EEPROM
// Contract
// R1: Outside sequences reads act as ROM; EEPROM writes store when unprotected.
// R2: Sequence bytes are decoded, not written; start only after full count.
// R3: Execute only if every inter-byte gap beats the time-out. Mode bytes 30, 90, A0 and 20 skip it and still act on the cycle it expires.
// R4: Flash bad byte or time-out aborts to read mode.
// R5: EEPROM bad byte or time-out becomes one plain write.
// R6: A15-A12 ignored; flash needs flash select, EEPROM needs EEPROM select.
// R7: Program: AA@555, 55@AAA, A0@555, data at target.
// R8: Sector erase: unlock, 80, unlock, 30 at sector; more 30s append.
// R9: Host adds further sectors within the window after the last one.
// R10: Chip erase: unlock, 80, unlock, 10 at 555.
// R11: B0 suspends sector erase, 30 resumes it.
// R12: Unlock, 90 then reads give identifier or protection by A6,A1,A0.
// R13: EEPROM unlock, 90 opens OTP row reading of consecutive bytes.
// R14: EEPROM unlock, 30 enters power-down.
// R15: EEPROM unlock, A0 enables protect and writes following bytes.
// R16: EEPROM unlock, 80, unlock, 20 disables protect.
// R17: EEPROM unlock, B0 writes OTP row, only while unprotected.
// R18: F0 on EEPROM ends OTP read or power-down.
// R19: Flash returns to read on unlock plus F0 or single F0.
// R20: After error or ID read flash stays out of read until reset.
// R21: Host avoids instructions on memory it executes from.
// R22: Device gives status readback and ready/busy output. The code gives ready/busy only; RDATA carries no status.
// R23: EEPROM write event accepts one to 64 bytes.
// R24: Ready/busy low while writing or erasing, high otherwise.
// R25: Reset to read mode; EEPROM writes blocked during lockout.
// R26: Time-out counter restarts per byte and applies abort on expiry.
module nvm_instruction_decoder
  import nvm_decoder_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int LOCKOUT_CYCLES = LOCKOUT_CYC
)(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic FLASH_SECTOR_SELECT,
  input wire logic EEPROM_SECTOR_SELECT,
  input wire logic ALGORITHM_ERROR_FLAG,
  input wire logic SECTOR_PROTECTED,
  input wire logic [7:0] FLASH_ID,
  output logic [7:0] RDATA,
  output logic RDATA_VALID,
  output logic SOURCE_ARRAY,
  output logic EEPROM_WRITE_STROBE,
  output logic OTP_WRITE_STROBE,
  output logic [15:0] WRITE_ADDR,
  output logic [7:0] WRITE_DATA,
  output logic FLASH_PROGRAM_START,
  output logic SECTOR_ERASE_ADD,
  output logic CHIP_ERASE_START,
  output logic ERASE_SUSPENDED,
  output logic EEPROM_WRITE_PROTECT_MODE,
  output logic EEPROM_POWER_DOWN,
  output logic OTP_READ_MODE,
  output logic [5:0] OTP_INDEX,
  output logic READY_BUSY_OUTPUT
);

  // ---------------------------------------------------------------
  // Sequence states
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_U1, S_U2, S_PROG, S_E80, S_E_U1, S_E_U2, S_ERASING,
                S_EE_BURST, S_OTP_WR} seq_t;
  seq_t state_reg, state_next;
  logic target_flash_reg; // Which memory the sequence addresses
  logic [31:0] gap_reg; // Cycles since last flash or EEPROM write
  logic [31:0] lock_reg; // Power-up lockout count
  logic [31:0] busy_reg; // Embedded algorithm busy count
  logic [6:0] burst_reg; // EEPROM write event byte count
  logic flash_ident_reg; // Flash in identifier/protection read mode
  logic flash_error_reg; // Error seen; flash waits for reset
  logic protect_reg, pdown_reg, otp_rd_reg, suspend_reg;
  logic [5:0] otp_idx_reg;

  function automatic logic is_cmd(input logic [15:0] a, input logic [7:0] d,
                                  input logic [11:0] ca, input logic [7:0] cd);
    is_cmd = (a[11:0] == ca) && (d == cd); // Upper nibble is don't care
  endfunction

  // Command byte of a short instruction, written to the first unlock address
  function automatic logic is_third(input seq_t st, input logic [15:0] a, input logic [7:0] d,
                                    input logic [7:0] cd);
    is_third = (st == S_U2) && is_cmd(a, d, ADDR_UNLOCK1, cd);
  endfunction

  // ---------------------------------------------------------------
  // Decode of the current write
  // ---------------------------------------------------------------
  wire fl_wr = WR_STROBE && FLASH_SECTOR_SELECT; // [R6]
  wire ee_wr = WR_STROBE && EEPROM_SECTOR_SELECT && !FLASH_SECTOR_SELECT; // [R6]
  wire any_wr = fl_wr || ee_wr;
  wire timed_out = (state_reg != S_IDLE) && (gap_reg >= 32'(TIMEOUT_CYCLES)); // [R3] [R26]
  wire locked = (lock_reg < 32'(LOCKOUT_CYCLES)); // [R25]
  wire busy = (busy_reg != 32'h0) || (state_reg == S_ERASING);
  wire w_u1 = is_cmd(ADDR, WDATA, ADDR_UNLOCK1, CODE_UNLOCK1);
  wire w_u2 = is_cmd(ADDR, WDATA, ADDR_UNLOCK2, CODE_UNLOCK2);
  wire w_at555 = (ADDR[11:0] == ADDR_UNLOCK1);
  wire ee_plain = ee_wr && !protect_reg && !pdown_reg && !otp_rd_reg && !locked; // [R1] [R25]

  // ---------------------------------------------------------------
  // Sequence decode
  // ---------------------------------------------------------------
  // A running erase keeps its state for further sectors and for suspend or resume
  wire erase_keep = (WDATA == CODE_SECTOR_ERASE) || (WDATA == CODE_SUSPEND); // [R8] [R11]
  logic abort_ee; // EEPROM offending byte as plain write
  always_comb
  begin
    state_next = state_reg;
    abort_ee = 1'b0;
    // An expired time-out with no write ends any sequence or write event; a running erase ignores it
    if (timed_out && !any_wr && state_reg != S_ERASING)
    begin
      state_next = S_IDLE; // [R4] [R26]
    end
    else if (any_wr)
    begin
      unique case (state_reg)
        S_IDLE:
          state_next = w_u1 ? S_U1 : S_IDLE;
        S_U1:
          state_next = w_u2 ? S_U2 : S_IDLE; // [R4]
        S_U2:
          if (target_flash_reg && WDATA == CODE_PROGRAM && w_at555)
            state_next = S_PROG; // [R7]
          else if (WDATA == CODE_ERASE_SETUP && w_at555)
            state_next = S_E80; // [R8] [R16]
          else if (!target_flash_reg && WDATA == CODE_PROGRAM && w_at555)
            state_next = S_EE_BURST; // [R15]
          else if (!target_flash_reg && WDATA == CODE_SUSPEND && w_at555 && !protect_reg)
            state_next = S_OTP_WR; // [R17]
          else
            state_next = S_IDLE;
        S_PROG:
          state_next = S_IDLE; // [R7]
        S_E80:
          state_next = w_u1 ? S_E_U1 : S_IDLE;
        S_E_U1:
          state_next = w_u2 ? S_E_U2 : S_IDLE;
        S_E_U2:
          if (target_flash_reg && WDATA == CODE_SECTOR_ERASE)
            state_next = S_ERASING; // [R8]
          else
            state_next = S_IDLE; // [R10] [R16]
        S_ERASING:
          state_next = erase_keep ? S_ERASING : S_IDLE; // [R8] [R9] [R11]
        S_EE_BURST, S_OTP_WR:
          state_next = (burst_reg + 7'h1 >= BURST_MAX) ? S_IDLE : state_reg; // [R23]
      endcase
      // Bad byte or late byte on EEPROM falls back to a plain write
      if (!target_flash_reg && state_reg != S_IDLE && state_reg != S_EE_BURST
          && state_reg != S_OTP_WR && (timed_out || state_next == S_IDLE)
          && !(state_reg == S_U2 && WDATA == CODE_SECTOR_ERASE && w_at555)
          && !(state_reg == S_U2 && WDATA == CODE_READ_ID && w_at555)
          && !(state_reg == S_E_U2 && WDATA == CODE_PROTECT_OFF && w_at555))
        abort_ee = 1'b1; // [R5]
      if (timed_out && state_reg != S_ERASING)
        state_next = w_u1 ? S_U1 : S_IDLE; // [R3]
    end
  end

  // ---------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state_reg <= S_IDLE; // [R25]
      target_flash_reg <= 1'b0;
      gap_reg <= 32'h0;
      burst_reg <= 7'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (any_wr && state_reg == S_IDLE)
        target_flash_reg <= fl_wr;
      gap_reg <= any_wr ? 32'h0 : (timed_out ? gap_reg : gap_reg + 32'h1); // [R26]
      if (any_wr && (state_reg == S_EE_BURST || state_reg == S_OTP_WR))
        burst_reg <= burst_reg + 7'h1;
      else if (state_next != S_EE_BURST && state_next != S_OTP_WR)
        burst_reg <= 7'h0;
    end
  end

  // ---------------------------------------------------------------
  // Mode flags: protect, power-down, OTP read, identifier, error, suspend
  // ---------------------------------------------------------------
  wire set_protect = ee_wr && state_reg == S_U2 && WDATA == CODE_PROGRAM && w_at555;
  wire clr_protect = ee_wr && state_reg == S_E_U2 && WDATA == CODE_PROTECT_OFF && w_at555;
  wire flash_reset = fl_wr && WDATA == CODE_RETURN
                     && (state_reg == S_IDLE || state_reg == S_U2); // [R19]
  wire ee_return = ee_wr && WDATA == CODE_RETURN && state_reg == S_IDLE; // [R18]
  // Short instructions that switch a read or power mode on
  wire set_pdown = ee_wr && is_third(state_reg, ADDR, WDATA, CODE_SECTOR_ERASE); // [R14]
  wire set_otp_rd = ee_wr && is_third(state_reg, ADDR, WDATA, CODE_READ_ID); // [R13]
  wire set_ident = fl_wr && is_third(state_reg, ADDR, WDATA, CODE_READ_ID); // [R12]
  // OTP reads walk the row from the address read, stopping at its last byte
  wire otp_step = RD_STROBE && EEPROM_SECTOR_SELECT && otp_rd_reg;
  wire [5:0] otp_next = (ADDR[5:0] == OTP_LAST) ? OTP_LAST : ADDR[5:0] + 6'h1; // [R13]
  // Suspend only means something while a sector erase runs; leaving erase drops it
  wire set_suspend = fl_wr && state_reg == S_ERASING && WDATA == CODE_SUSPEND; // [R11]
  wire clr_suspend = (fl_wr && suspend_reg && WDATA == CODE_SECTOR_ERASE)
                     || (state_reg != S_ERASING); // [R11]

  // Flag registers; every set wins over a clear in the same cycle
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      protect_reg <= 1'b0;
      pdown_reg <= 1'b0;
      otp_rd_reg <= 1'b0;
      otp_idx_reg <= 6'h0;
      flash_ident_reg <= 1'b0;
      flash_error_reg <= 1'b0;
      suspend_reg <= 1'b0;
    end
    else
    begin
      if (set_protect)
        protect_reg <= 1'b1; // [R15]
      else if (clr_protect)
        protect_reg <= 1'b0; // [R16]
      if (set_pdown)
        pdown_reg <= 1'b1; // [R14]
      else if (ee_return)
        pdown_reg <= 1'b0; // [R18]
      if (set_otp_rd)
        otp_rd_reg <= 1'b1; // [R13]
      else if (ee_return)
        otp_rd_reg <= 1'b0; // [R18]
      if (ee_return)
        otp_idx_reg <= 6'h0;
      else if (otp_step)
        otp_idx_reg <= otp_next; // [R13]
      if (ALGORITHM_ERROR_FLAG)
        flash_error_reg <= 1'b1; // [R20]
      else if (flash_reset)
        flash_error_reg <= 1'b0; // [R20]
      if (set_ident)
        flash_ident_reg <= 1'b1; // [R12]
      else if (flash_reset)
        flash_ident_reg <= 1'b0; // [R19] [R20]
      if (set_suspend)
        suspend_reg <= 1'b1; // [R11]
      else if (clr_suspend)
        suspend_reg <= 1'b0; // [R11]
    end
  end

  // ---------------------------------------------------------------
  // Launch pulses, write path and busy timing
  // ---------------------------------------------------------------
  wire launch_prog = fl_wr && state_reg == S_PROG && !timed_out; // [R2] [R7]
  wire launch_sector = fl_wr && WDATA == CODE_SECTOR_ERASE && !timed_out
                       && !suspend_reg
                       && (state_reg == S_E_U2 || state_reg == S_ERASING); // [R8] [R11]
  wire launch_chip = fl_wr && state_reg == S_E_U2 && WDATA == CODE_CHIP_ERASE
                     && w_at555 && !timed_out; // [R10]
  wire ee_seq_wr = ee_wr && !locked && !timed_out && !pdown_reg
                   && (state_reg == S_EE_BURST || state_reg == S_OTP_WR); // [R15] [R17]
  wire ee_store = ee_seq_wr && state_reg == S_EE_BURST
                  || (ee_plain && (state_reg == S_IDLE && !w_u1 || abort_ee)); // [R1] [R5]
  wire otp_store = ee_seq_wr && state_reg == S_OTP_WR; // [R17]
  // Any launch or store pulls ready low at once
  wire op_start = launch_prog || launch_chip || launch_sector || ee_store || otp_store;
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      lock_reg <= 32'h0;
      busy_reg <= 32'h0;
      EEPROM_WRITE_STROBE <= 1'b0;
      OTP_WRITE_STROBE <= 1'b0;
      FLASH_PROGRAM_START <= 1'b0;
      SECTOR_ERASE_ADD <= 1'b0;
      CHIP_ERASE_START <= 1'b0;
      WRITE_ADDR <= 16'h0;
      WRITE_DATA <= 8'h0;
      READY_BUSY_OUTPUT <= 1'b1;
    end
    else
    begin
      lock_reg <= locked ? lock_reg + 32'h1 : lock_reg; // [R25]
      if (launch_prog || launch_chip || ee_store || otp_store)
        busy_reg <= 32'(OP_CYC);
      else if (busy_reg != 32'h0)
        busy_reg <= busy_reg - 32'h1;
      EEPROM_WRITE_STROBE <= ee_store;
      OTP_WRITE_STROBE <= otp_store;
      FLASH_PROGRAM_START <= launch_prog && !SECTOR_PROTECTED;
      SECTOR_ERASE_ADD <= launch_sector;
      CHIP_ERASE_START <= launch_chip;
      if (any_wr)
      begin
        WRITE_ADDR <= ADDR;
        WRITE_DATA <= WDATA;
      end
      READY_BUSY_OUTPUT <= !(busy || op_start) || suspend_reg; // [R22] [R24]
    end
  end

  // ---------------------------------------------------------------
  // Read path: array, identifier or protection
  // ---------------------------------------------------------------
  wire [2:0] id_sel = {ADDR[6], ADDR[1], ADDR[0]};
  wire fl_rd = RD_STROBE && FLASH_SECTOR_SELECT;
  wire ee_rd = RD_STROBE && EEPROM_SECTOR_SELECT && !FLASH_SECTOR_SELECT;
  wire rd_ident = fl_rd && flash_ident_reg && id_sel == SEL_IDENT; // [R12]
  wire rd_prot = fl_rd && flash_ident_reg && id_sel == SEL_PROTECT; // [R12]
  // Answer byte and the array-read flag, settled before the register stage
  wire [7:0] prot_byte = SECTOR_PROTECTED ? ONE_BYTE : ZERO_BYTE;
  wire [7:0] rd_byte = rd_ident ? FLASH_ID : (rd_prot ? prot_byte : ZERO_BYTE);
  wire array_rd = (fl_rd && !flash_ident_reg && !flash_error_reg)
                  || (ee_rd && !pdown_reg && !otp_rd_reg); // [R1] [R20]
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      RDATA <= 8'h0;
      RDATA_VALID <= 1'b0;
      SOURCE_ARRAY <= 1'b0;
    end
    else
    begin
      RDATA <= rd_byte; // [R12]
      RDATA_VALID <= rd_ident || rd_prot;
      SOURCE_ARRAY <= array_rd; // [R1] [R20]
    end
  end

  assign ERASE_SUSPENDED = suspend_reg;
  assign EEPROM_WRITE_PROTECT_MODE = protect_reg;
  assign EEPROM_POWER_DOWN = pdown_reg;
  assign OTP_READ_MODE = otp_rd_reg;
  assign OTP_INDEX = otp_idx_reg;

endmodule // nvm_instruction_decoder

// ### tb/nvm_decoder_chk.sv
// Port assertions for the flash and EEPROM instruction decoder
module nvm_decoder_chk
  import nvm_decoder_pkg::*;
#(
  parameter int LOCKOUT_CYCLES = 50
)(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic FLASH_SECTOR_SELECT,
  input wire logic [7:0] WRITE_DATA,
  input wire logic EEPROM_WRITE_STROBE,
  input wire logic OTP_WRITE_STROBE,
  input wire logic FLASH_PROGRAM_START,
  input wire logic CHIP_ERASE_START,
  input wire logic SECTOR_ERASE_ADD,
  input wire logic RDATA_VALID,
  input wire logic EEPROM_WRITE_PROTECT_MODE,
  input wire logic EEPROM_POWER_DOWN,
  input wire logic READY_BUSY_OUTPUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  int lock_cnt;
  // Cycles since reset release, saturating once the lockout is over
  always_ff @(posedge REF_CLK)
  begin
    if (RST) lock_cnt <= 0;
    else if (lock_cnt < LOCKOUT_CYCLES) lock_cnt <= lock_cnt + 1;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_start_cause: assert property (FLASH_PROGRAM_START |-> $past(WR_STROBE)
    && $past(FLASH_SECTOR_SELECT)) else $error("program start without flash write");
  a_program_busy: assert property (FLASH_PROGRAM_START |=> !READY_BUSY_OUTPUT [*8])
    else $error("ready during programming");
  a_store_data: assert property (EEPROM_WRITE_STROBE |-> $past(WR_STROBE)
    && WRITE_DATA == $past(WDATA)) else $error("EEPROM store data wrong");
  a_lockout_block: assert property (EEPROM_WRITE_STROBE |-> lock_cnt >= LOCKOUT_CYCLES)
    else $error("EEPROM store during lockout");
  a_power_block: assert property ($past(EEPROM_POWER_DOWN) |-> !EEPROM_WRITE_STROBE)
    else $error("EEPROM store in power-down");
  a_otp_protect: assert property (OTP_WRITE_STROBE |-> !$past(EEPROM_WRITE_PROTECT_MODE))
    else $error("OTP write while protected");
  a_chip_cause: assert property (CHIP_ERASE_START |-> $past(WDATA) == CODE_CHIP_ERASE
    && $past(ADDR[11:0]) == ADDR_UNLOCK1) else $error("chip erase wrong cause");
  a_sector_cause: assert property (SECTOR_ERASE_ADD |-> $past(WDATA) == CODE_SECTOR_ERASE)
    else $error("sector erase wrong cause");
  a_read_answer: assert property (RDATA_VALID |-> $past(RD_STROBE))
    else $error("read data without read");
  a_reset_ready: assert property ($past(RST) |-> READY_BUSY_OUTPUT && !EEPROM_POWER_DOWN)
    else $error("not ready after reset");
  c_program: cover property (FLASH_PROGRAM_START);
  c_chip: cover property (CHIP_ERASE_START);
  c_store: cover property (EEPROM_WRITE_STROBE);
endmodule // nvm_decoder_chk

bind nvm_instruction_decoder nvm_decoder_chk #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) chk (
  .REF_CLK(REF_CLK), .RST(RST), .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE),
  .ADDR(ADDR), .WDATA(WDATA), .FLASH_SECTOR_SELECT(FLASH_SECTOR_SELECT),
  .WRITE_DATA(WRITE_DATA), .EEPROM_WRITE_STROBE(EEPROM_WRITE_STROBE),
  .OTP_WRITE_STROBE(OTP_WRITE_STROBE), .FLASH_PROGRAM_START(FLASH_PROGRAM_START),
  .CHIP_ERASE_START(CHIP_ERASE_START), .SECTOR_ERASE_ADD(SECTOR_ERASE_ADD),
  .RDATA_VALID(RDATA_VALID), .EEPROM_WRITE_PROTECT_MODE(EEPROM_WRITE_PROTECT_MODE),
  .EEPROM_POWER_DOWN(EEPROM_POWER_DOWN), .READY_BUSY_OUTPUT(READY_BUSY_OUTPUT));

// ### tb/mcu_bus_model.sv
// Microcontroller bus master model driving one-cycle read and write strobes
module mcu_bus_model
(
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic fs,
  output logic es
);
  timeunit 1ns;
  timeprecision 100ps;
  // Lines start idle with no memory selected
  initial
  begin
    {wr, rd, fs, es} = 4'h0;
    addr = 16'h0000;
    wdata = 8'h00;
  end
  // One bus cycle with the strobe, address, data and selects that the caller gives
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic f, input logic e);
    @(posedge clk);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    fs = f;
    es = e;
    @(posedge clk);
    #1;
    {wr, rd, fs, es} = 4'h0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule // mcu_bus_model

// ### tb/nvm_instruction_decoder_test.sv
// Self-checking bench for the instruction decoder
module nvm_instruction_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  import nvm_decoder_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic err_flag = 1'b0;
  logic prot = 1'b0;
  logic [7:0] flash_id = 8'hC4; // Arbitrary identifier value
  wire wr, rd, fs, es;
  wire [15:0] addr;
  wire [7:0] wdata;
  int fails = 0;
  int total_checks = 0;
  // ----------------------------------------
  // Clock, model and design
  // ----------------------------------------
  initial forever #20 ref_clk = ~ref_clk;
  mcu_bus_model mcu (.clk(ref_clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .fs(fs), .es(es));
  nvm_instruction_decoder #(.TIMEOUT_CYCLES(20), .LOCKOUT_CYCLES(50)) dut (
    .REF_CLK(ref_clk), .RST(rst), .WR_STROBE(wr), .RD_STROBE(rd), .ADDR(addr),
    .WDATA(wdata), .FLASH_SECTOR_SELECT(fs), .EEPROM_SECTOR_SELECT(es),
    .ALGORITHM_ERROR_FLAG(err_flag), .SECTOR_PROTECTED(prot), .FLASH_ID(flash_id),
    .RDATA(), .RDATA_VALID(), .SOURCE_ARRAY(), .EEPROM_WRITE_STROBE(),
    .OTP_WRITE_STROBE(), .WRITE_ADDR(), .WRITE_DATA(), .FLASH_PROGRAM_START(),
    .SECTOR_ERASE_ADD(), .CHIP_ERASE_START(), .ERASE_SUSPENDED(),
    .EEPROM_WRITE_PROTECT_MODE(), .EEPROM_POWER_DOWN(), .OTP_READ_MODE(),
    .OTP_INDEX(), .READY_BUSY_OUTPUT());
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset(input int settle);
    @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (settle) @(posedge ref_clk);
  endtask
  task automatic w(input logic f, input logic [15:0] a, input logic [7:0] d);
    mcu.bus(1'b1, a, d, f, !f);
  endtask
  task automatic r(input logic f, input logic [15:0] a);
    mcu.bus(1'b0, a, 8'h00, f, !f);
  endtask
  // Unlock pair with the ignored upper address bits set
  task automatic unlock(input logic f);
    w(f, {4'hA, ADDR_UNLOCK1}, CODE_UNLOCK1);
    w(f, {4'h5, ADDR_UNLOCK2}, CODE_UNLOCK2);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_lockout;
    check(16'(dut.READY_BUSY_OUTPUT), 16'h1);
    w(1'b0, 16'h0100, 8'h5A);
    check(16'(dut.EEPROM_WRITE_STROBE), 16'h0);
    repeat (60) @(posedge ref_clk);
    w(1'b0, 16'h0100, 8'h5A);
    check({dut.WRITE_DATA, 7'h0, dut.EEPROM_WRITE_STROBE}, 16'h5A01);
    check(dut.WRITE_ADDR, 16'h0100);
    $display("t_lockout done");
  endtask
  task automatic t_program;
    unlock(1'b1);
    w(1'b1, {4'h7, ADDR_UNLOCK1}, CODE_PROGRAM);
    w(1'b1, 16'h1234, 8'h5A);
    check({dut.FLASH_PROGRAM_START, dut.READY_BUSY_OUTPUT}, 16'h2);
    for (int i = 0; i < 40 && !dut.READY_BUSY_OUTPUT; i++) @(posedge ref_clk);
    check(16'(dut.READY_BUSY_OUTPUT), 16'h1);
    unlock(1'b1);
    repeat (25) @(posedge ref_clk);
    w(1'b1, ADDR_UNLOCK1, CODE_PROGRAM);
    w(1'b1, 16'h1234, 8'h5A);
    check(16'(dut.FLASH_PROGRAM_START), 16'h0);
    w(1'b0, 16'h0555, CODE_UNLOCK1);
    w(1'b0, 16'h0AAA, 8'h12);
    check({dut.WRITE_DATA, 7'h0, dut.EEPROM_WRITE_STROBE}, 16'h1201);
    $display("t_program done");
  endtask
  task automatic t_ident;
    unlock(1'b1);
    w(1'b1, ADDR_UNLOCK1, CODE_READ_ID);
    r(1'b1, 16'h0001);
    check({dut.RDATA, 6'h0, dut.RDATA_VALID, dut.SOURCE_ARRAY}, {flash_id, 8'h02});
    prot = 1'b1;
    r(1'b1, 16'h0002);
    check(16'(dut.RDATA), 16'h0001);
    unlock(1'b1);
    w(1'b1, 16'h0000, CODE_RETURN);
    r(1'b1, 16'h0040);
    check(16'(dut.SOURCE_ARRAY), 16'h1);
    err_flag = 1'b1;
    @(posedge ref_clk);
    #1 err_flag = 1'b0;
    r(1'b1, 16'h0040);
    check(16'(dut.SOURCE_ARRAY), 16'h0);
    w(1'b1, 16'h0000, CODE_RETURN);
    r(1'b1, 16'h0040);
    check(16'(dut.SOURCE_ARRAY), 16'h1);
    $display("t_ident done");
  endtask
  task automatic t_eeprom_modes;
    unlock(1'b0);
    w(1'b0, ADDR_UNLOCK1, CODE_SECTOR_ERASE);
    check(16'(dut.EEPROM_POWER_DOWN), 16'h1);
    w(1'b0, 16'h0100, 8'h11);
    check(16'(dut.EEPROM_WRITE_STROBE), 16'h0);
    w(1'b0, 16'h0000, CODE_RETURN);
    check(16'(dut.EEPROM_POWER_DOWN), 16'h0);
    unlock(1'b0);
    w(1'b0, ADDR_UNLOCK1, CODE_PROGRAM);
    w(1'b0, 16'h0200, 8'h22);
    check({dut.EEPROM_WRITE_PROTECT_MODE, dut.EEPROM_WRITE_STROBE}, 16'h3);
    repeat (25) @(posedge ref_clk);
    unlock(1'b0);
    check(16'(dut.EEPROM_WRITE_STROBE), 16'h0);
    w(1'b0, ADDR_UNLOCK1, CODE_SUSPEND);
    w(1'b0, 16'h0000, 8'h33);
    check(16'(dut.OTP_WRITE_STROBE), 16'h0);
    unlock(1'b0);
    w(1'b0, ADDR_UNLOCK1, CODE_ERASE_SETUP);
    unlock(1'b0);
    w(1'b0, ADDR_UNLOCK1, CODE_PROTECT_OFF);
    check(16'(dut.EEPROM_WRITE_PROTECT_MODE), 16'h0);
    unlock(1'b0);
    w(1'b0, ADDR_UNLOCK1, CODE_SUSPEND);
    w(1'b0, 16'h0005, 8'h33);
    check({dut.WRITE_DATA, 7'h0, dut.OTP_WRITE_STROBE}, 16'h3301);
    repeat (25) @(posedge ref_clk);
    unlock(1'b0);
    w(1'b0, ADDR_UNLOCK1, CODE_READ_ID);
    r(1'b0, 16'h0000);
    check({dut.OTP_READ_MODE, 9'h0, dut.OTP_INDEX}, 16'h8001);
    w(1'b0, 16'h0000, CODE_RETURN);
    check(16'(dut.OTP_READ_MODE), 16'h0);
    $display("t_eeprom_modes done");
  endtask
  task automatic t_erase;
    unlock(1'b1);
    w(1'b1, ADDR_UNLOCK1, CODE_ERASE_SETUP);
    unlock(1'b1);
    w(1'b1, 16'h2100, CODE_SECTOR_ERASE);
    check(16'(dut.SECTOR_ERASE_ADD), 16'h1);
    w(1'b1, 16'h3000, CODE_SECTOR_ERASE);
    check(16'(dut.SECTOR_ERASE_ADD), 16'h1);
    w(1'b1, 16'h0000, CODE_SUSPEND);
    check(16'(dut.ERASE_SUSPENDED), 16'h1);
    w(1'b1, 16'h0000, CODE_SECTOR_ERASE);
    check(16'(dut.ERASE_SUSPENDED), 16'h0);
    check(16'(dut.SECTOR_ERASE_ADD), 16'h0);
    do_reset(2);
    unlock(1'b1);
    w(1'b1, ADDR_UNLOCK1, CODE_ERASE_SETUP);
    unlock(1'b1);
    w(1'b1, ADDR_UNLOCK1, CODE_CHIP_ERASE);
    check({dut.CHIP_ERASE_START, dut.READY_BUSY_OUTPUT}, 16'h2);
    $display("t_erase done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    do_reset(0);
    t_lockout();
    t_program();
    t_ident();
    t_eeprom_modes();
    t_erase();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run();
  end
endmodule // nvm_instruction_decoder_test
